/* hw/wdt_pkg.sv */
/*
 Constants for the window watchdog: register offsets, field positions,
 reset values and timing counts.
 Assumes a 50 MHz system clock and a nominal 32 kHz low-power RC rate.
*/
package wdt_pkg;
	// Register byte offsets
	localparam logic [3:0] CONFIG_OFFSET = 4'h0;
	localparam logic [3:0] RESET_CONTROL_OFFSET = 4'h4;
	localparam logic [3:0] COMMAND_OFFSET = 4'h8;
	localparam logic [3:0] STATUS_OFFSET = 4'hC;

	// Config word fields
	localparam int POSTSCALE_LSB = 0;
	localparam int PRESCALE_SELECT_BIT = 4;
	localparam int ALWAYS_ON_BIT = 5;
	localparam int WINDOW_DISABLE_BIT = 6;
	localparam logic [6:0] CONFIG_RESET = 7'h5F;

	// Reset control fields
	localparam int IDLE_STATUS_BIT = 2;
	localparam int SLEEP_STATUS_BIT = 3;
	localparam int TIMEOUT_FLAG_BIT = 4;
	localparam int SOFT_ENABLE_BIT = 5;

	// Command fields, write-only strobes
	localparam int CMD_KICK_BIT = 0;
	localparam int CMD_SLEEP_BIT = 1;
	localparam int CMD_IDLE_BIT = 2;
	localparam int CMD_RESUME_BIT = 3;

	// Status fields
	localparam int STAT_RUNNING_BIT = 0;
	localparam int STAT_WINDOW_OPEN_BIT = 1;
	localparam int STAT_POST_LSB = 16;

	// Prescaler terminal counts: divide by 32 or by 128
	localparam logic [6:0] PRE_LAST_DIV32 = 7'h1F;
	localparam logic [6:0] PRE_LAST_DIV128 = 7'h7F;

	// Nominal base periods in microseconds at 32 kHz
	localparam int BASE_PERIOD_US_DIV32 = 1000;
	localparam int BASE_PERIOD_US_DIV128 = 4000;

	// Low-power RC tick derived from the system clock
	localparam int CLK_FREQ_HZ = 50000000;
	localparam int LOW_POWER_RC_CLOCK_FREQ_HZ = 32000;
	localparam int LOW_POWER_RC_CLOCK_TICK_CYCLES = CLK_FREQ_HZ / LOW_POWER_RC_CLOCK_FREQ_HZ;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_IDLE} power_state_t;
endpackage

/* hw/window_watchdog_timer.sv */
/*
 Window watchdog timer with prescaler, postscaler, window check and
 sleep/idle wake-up, reached over an AXI4-Lite slave port.
 Assumes all inputs synchronous to clk_in and an active-low async reset.
*/
// Chosen here: the AXI4-Lite register port and the register addresses.
// How it works
// - Counts low-power RC ticks (32 kHz); enabling watchdog enables oscillator.
// - Prescaler divides by 32 or 128 per prescale_select.
// - Base period is 1 ms (divide 32) or 4 ms (divide 128).
// - Postscaler after prescaler, 4-bit field selects 16 ratios up to 1:32768.
// - Any device reset zeroes counter, prescaler and postscaler.
// - Clock switch completion clears counter, prescaler and postscaler.
// - Entering sleep or idle clears all watchdog counts.
// - Leaving sleep or idle back to run clears all watchdog counts.
// - Kick instruction in normal run clears all watchdog counts.
// - Enabled watchdog keeps counting in sleep and idle.
// - Timeout in sleep or idle wakes the core, no reset.
// - Sleep and idle status bits stay set until software clears them.
// - Timeout flag set on timeout, held until software clears it.
// - always_on_config set runs watchdog regardless of soft_enable.
// - always_on_config clear runs watchdog only while soft_enable set.
// - Every device reset clears soft_enable.
// - Window mode kick before final quarter causes a watchdog reset.
// - prescale_select one gives divide 128, zero gives divide 32.
// - window_disable one is non-window, zero is window mode.
// - Code 1111 gives 1:32768, 1110 gives 1:16384, halving downward.
`timescale 1ns/1ps
module window_watchdog_timer
	import wdt_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Core events
	input wire logic clock_switch_done_in,
	// AXI4-Lite write address and data
	input wire logic s_axi_awvalid_in,
	input wire logic [3:0] s_axi_awaddr_in,
	output logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	output logic s_axi_wready_out,
	// AXI4-Lite write response
	output logic s_axi_bvalid_out,
	output logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_bready_in,
	// AXI4-Lite read
	input wire logic s_axi_arvalid_in,
	input wire logic [3:0] s_axi_araddr_in,
	output logic s_axi_arready_out,
	output logic s_axi_rvalid_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	input wire logic s_axi_rready_in,
	// Device-level effects
	output logic device_reset_out,
	output logic wake_out,
	output logic low_power_rc_clock_on_out,
	output logic sleep_out,
	output logic idle_out
);
	// Configuration and control state
	logic [6:0] watchdog_config_word;
	logic soft_enable;
	logic timeout_flag;
	logic sleep_status;
	logic idle_status;
	power_state_t power_state;

	// Counting chain
	logic [10:0] low_power_rc_clock_count;
	logic [6:0] pre_count;
	logic [14:0] post_count;

	// Bus capture
	logic aw_full;
	logic w_full;
	logic [3:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;

	wire [3:0] postscale_select = watchdog_config_word[POSTSCALE_LSB +: 4];
	wire prescale_select = watchdog_config_word[PRESCALE_SELECT_BIT];
	wire always_on_config = watchdog_config_word[ALWAYS_ON_BIT];
	wire window_disable = watchdog_config_word[WINDOW_DISABLE_BIT];

	wire wdt_enabled = always_on_config | soft_enable;

	// Oscillator tick, only while the watchdog runs
	wire low_power_rc_clock_tick = wdt_enabled && (low_power_rc_clock_count == 11'(LOW_POWER_RC_CLOCK_TICK_CYCLES - 1));

	wire [6:0] pre_last = prescale_select ? PRE_LAST_DIV128 : PRE_LAST_DIV32;
	wire pre_wrap = low_power_rc_clock_tick && (pre_count == pre_last);
	wire [15:0] post_span = 16'h1 << postscale_select;
	wire [14:0] post_last = 15'(post_span - 16'h1);
	wire timeout = pre_wrap && (post_count == post_last);

	// Elapsed time against the final-quarter threshold
	wire [22:0] elapsed = prescale_select ? {1'b0, post_count, pre_count} :
		{3'b000, post_count, pre_count[4:0]};
	wire [4:0] total_log = 5'(postscale_select) + (prescale_select ? 5'h07 : 5'h05);
	wire [22:0] total_ticks = 23'h1 << total_log;
	wire [22:0] window_start = total_ticks - (total_ticks >> 2);
	wire window_open = elapsed >= window_start;

	// Write path decode
	wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
	wire w_take = s_axi_wvalid_in && s_axi_wready_out;
	wire wr_fire = aw_full && w_full && !s_axi_bvalid_out;
	wire wr_config = wr_fire && (wr_addr == CONFIG_OFFSET);
	wire wr_reset_control_reg = wr_fire && (wr_addr == RESET_CONTROL_OFFSET);
	wire wr_cmd = wr_fire && (wr_addr == COMMAND_OFFSET);
	wire wr_mapped = (wr_addr == CONFIG_OFFSET) || (wr_addr == RESET_CONTROL_OFFSET) ||
		(wr_addr == COMMAND_OFFSET) || (wr_addr == STATUS_OFFSET);

	// Commands from software, low byte only
	wire cmd_valid = wr_cmd && wr_strb[0];
	wire running = (power_state == PWR_RUN);
	wire kick = cmd_valid && wr_data[CMD_KICK_BIT] && running;
	wire enter_sleep = cmd_valid && wr_data[CMD_SLEEP_BIT] && running;
	wire enter_idle = cmd_valid && wr_data[CMD_IDLE_BIT] && running && !enter_sleep;
	wire resume = cmd_valid && wr_data[CMD_RESUME_BIT] && !running;

	// Watchdog outcomes
	wire early_kick = kick && wdt_enabled && !window_disable && !window_open;
	wire run_timeout = timeout && running;
	wire sleep_timeout = timeout && !running;
	wire wdt_reset = run_timeout || early_kick;
	wire wake = sleep_timeout || resume;

	// Any clearing event zeroes the whole chain
	wire chain_clear = wdt_reset || clock_switch_done_in || kick ||
		enter_sleep || enter_idle || wake || !wdt_enabled;

	// Software flag clears: writing zero clears, writing one does nothing
	wire reset_control_reg_lane = wr_reset_control_reg && wr_strb[0];
	wire clr_timeout = reset_control_reg_lane && !wr_data[TIMEOUT_FLAG_BIT];
	wire clr_sleep = reset_control_reg_lane && !wr_data[SLEEP_STATUS_BIT];
	wire clr_idle = reset_control_reg_lane && !wr_data[IDLE_STATUS_BIT];

	wire next_aw_full = wr_fire ? 1'b0 : (aw_full || aw_take);
	wire next_w_full = wr_fire ? 1'b0 : (w_full || w_take);
	wire next_bvalid = wr_fire || (s_axi_bvalid_out && !s_axi_bready_in);

	// Read decode
	wire ar_take = s_axi_arvalid_in && s_axi_arready_out;
	wire [31:0] status_word = {1'b0, post_count, 14'h0000, window_open, wdt_enabled};
	wire [31:0] reset_control_reg_word = {26'h0000000, soft_enable, timeout_flag, sleep_status,
		idle_status, 2'b00};
	wire rd_mapped = (s_axi_araddr_in == CONFIG_OFFSET) ||
		(s_axi_araddr_in == RESET_CONTROL_OFFSET) || (s_axi_araddr_in == COMMAND_OFFSET) ||
		(s_axi_araddr_in == STATUS_OFFSET);
	wire [31:0] rd_word = (s_axi_araddr_in == CONFIG_OFFSET) ? {25'h0000000, watchdog_config_word} :
		(s_axi_araddr_in == RESET_CONTROL_OFFSET) ? reset_control_reg_word :
		(s_axi_araddr_in == STATUS_OFFSET) ? status_word : 32'h00000000;

	// Write channels: address and data may arrive in either order
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			wr_addr <= 4'h0;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out <= 1'b1;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= RESP_OKAY;
		end
		else
		begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			if (aw_take)
				wr_addr <= s_axi_awaddr_in;
			if (w_take)
			begin
				wr_data <= s_axi_wdata_in;
				wr_strb <= s_axi_wstrb_in;
			end
			s_axi_awready_out <= !next_aw_full && !next_bvalid;
			s_axi_wready_out <= !next_w_full && !next_bvalid;
			s_axi_bvalid_out <= next_bvalid;
			if (wr_fire)
				s_axi_bresp_out <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// Read channel, one outstanding read
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h00000000;
			s_axi_rresp_out <= RESP_OKAY;
		end
		else if (ar_take)
		begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b1;
			s_axi_rdata_out <= rd_word;
			s_axi_rresp_out <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid_out && s_axi_rready_in)
		begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out <= 1'b0;
		end
	end

	// Config word, writable only through the low byte
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			watchdog_config_word <= CONFIG_RESET;
		else if (wr_config && wr_strb[0])
			watchdog_config_word <= wr_data[6:0];
	end

	// Soft enable; a watchdog reset is a device reset and drops it too
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			soft_enable <= 1'b0;
		else if (wdt_reset)
			soft_enable <= 1'b0;
		else if (reset_control_reg_lane)
			soft_enable <= wr_data[SOFT_ENABLE_BIT];
	end

	// Sticky flags: a set in the same cycle as a clear wins
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			timeout_flag <= 1'b0;
			sleep_status <= 1'b0;
			idle_status <= 1'b0;
		end
		else
		begin
			if (timeout || early_kick)
				timeout_flag <= 1'b1;
			else if (clr_timeout)
				timeout_flag <= 1'b0;
			if (enter_sleep)
				sleep_status <= 1'b1;
			else if (clr_sleep)
				sleep_status <= 1'b0;
			if (enter_idle)
				idle_status <= 1'b1;
			else if (clr_idle)
				idle_status <= 1'b0;
		end
	end

	// Power state: a timeout in sleep or idle returns to run, no reset
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			power_state <= PWR_RUN;
		else
		begin
			unique case (power_state)
				PWR_RUN:
					if (enter_sleep)
						power_state <= PWR_SLEEP;
					else if (enter_idle)
						power_state <= PWR_IDLE;
				PWR_SLEEP, PWR_IDLE:
					if (wake)
						power_state <= PWR_RUN;
				default:
					power_state <= PWR_RUN;
			endcase
		end
	end

	// Counting chain; held at zero while disabled
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			low_power_rc_clock_count <= 11'h000;
			pre_count <= 7'h00;
			post_count <= 15'h0000;
		end
		else if (chain_clear)
		begin
			low_power_rc_clock_count <= 11'h000;
			pre_count <= 7'h00;
			post_count <= 15'h0000;
		end
		else
		begin
			low_power_rc_clock_count <= low_power_rc_clock_tick ? 11'h000 : low_power_rc_clock_count + 11'h001;
			if (pre_wrap)
			begin
				pre_count <= 7'h00;
				post_count <= post_count + 15'h0001;
			end
			else if (low_power_rc_clock_tick)
				pre_count <= pre_count + 7'h01;
		end
	end

	// Device-level outputs
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			device_reset_out <= 1'b0;
			wake_out <= 1'b0;
			low_power_rc_clock_on_out <= 1'b0;
			sleep_out <= 1'b0;
			idle_out <= 1'b0;
		end
		else
		begin
			device_reset_out <= wdt_reset;
			wake_out <= sleep_timeout;
			low_power_rc_clock_on_out <= wdt_enabled;
			sleep_out <= (power_state == PWR_SLEEP);
			idle_out <= (power_state == PWR_IDLE);
		end
	end
endmodule

/* verification/wdt_asserts.sv */
/*
 Port checker for the window watchdog: pulse widths, wake-up and bus holds.
 Bound to every window_watchdog_timer instance below; one clock domain.
*/
`timescale 1ns/1ps
module wdt_asserts
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Bus
	input wire logic s_axi_bvalid_out,
	input wire logic [1:0] s_axi_bresp_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic s_axi_rready_in,
	// Device effects
	input wire logic device_reset_out,
	input wire logic wake_out,
	input wire logic low_power_rc_clock_on_out,
	input wire logic sleep_out,
	input wire logic idle_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!arst_n_in);

	rst_pulse_a: assert property (device_reset_out |=> !device_reset_out)
		else $error("device reset pulse too wide");
	wake_pulse_a: assert property (wake_out |=> !wake_out)
		else $error("wake pulse too wide");
	wake_src_a: assert property (wake_out |-> $past(sleep_out || idle_out))
		else $error("wake without sleep or idle");
	wake_resume_a: assert property (wake_out |-> ##[0:2] !(sleep_out || idle_out))
		else $error("core did not resume after wake");
	wake_rc_a: assert property (wake_out |-> $past(low_power_rc_clock_on_out))
		else $error("wake while watchdog clock off");
	wake_no_rst_a: assert property (!(wake_out && device_reset_out))
		else $error("wake and device reset together");
	mode_excl_a: assert property (!(sleep_out && idle_out))
		else $error("sleep and idle together");
	b_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in
		|=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
		else $error("write response dropped early");
	r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
		|=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
		else $error("read data dropped early");
	rd_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read answer late");

	cover property (wake_out);
	cover property (device_reset_out);
	cover property (s_axi_rvalid_out && s_axi_rready_in);
endmodule

bind window_watchdog_timer wdt_asserts wdt_chk
(
	.clk_in(clk_in),
	.arst_n_in(arst_n_in),
	.s_axi_bvalid_out(s_axi_bvalid_out),
	.s_axi_bresp_out(s_axi_bresp_out),
	.s_axi_bready_in(s_axi_bready_in),
	.s_axi_arvalid_in(s_axi_arvalid_in),
	.s_axi_arready_out(s_axi_arready_out),
	.s_axi_rvalid_out(s_axi_rvalid_out),
	.s_axi_rdata_out(s_axi_rdata_out),
	.s_axi_rready_in(s_axi_rready_in),
	.device_reset_out(device_reset_out),
	.wake_out(wake_out),
	.low_power_rc_clock_on_out(low_power_rc_clock_on_out),
	.sleep_out(sleep_out),
	.idle_out(idle_out)
);

/* verification/test_window_watchdog_timer.sv */
/*
 Self-checking bench for the window watchdog, driven over AXI4-Lite.
 Assumes the package, design and checker are compiled before it.
*/
`timescale 1ns/1ps
module test_window_watchdog_timer;
	import wdt_pkg::*;
	logic clk_in, arst_n_in, clock_switch_done_in;
	logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
	logic [3:0] s_axi_awaddr_in, s_axi_araddr_in, s_axi_wstrb_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd;
	logic s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
	logic s_axi_rvalid_out, s_axi_rready_in;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp;
	logic device_reset_out, wake_out, low_power_rc_clock_on_out, sleep_out, idle_out;
	int bad_count, n_tests, cyc, rst_count, rst_base, t0;
	// Shortest timeout: divide by 32, postscale code 0
	localparam int PERIOD = 32 * LOW_POWER_RC_CLOCK_TICK_CYCLES;
	// In window mode a kick is legal only in the last quarter
	localparam int WIN = PERIOD * 3 / 4;
	// Tick phase restarts with the counts; slack covers sampling offsets
	localparam int SLACK = 8;
	// Two full timeouts plus bus traffic and short gaps
	localparam int LIMIT = 2 * PERIOD + 3000;

	window_watchdog_timer DUT
	(
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.clock_switch_done_in(clock_switch_done_in),
		.s_axi_awvalid_in(s_axi_awvalid_in),
		.s_axi_awaddr_in(s_axi_awaddr_in),
		.s_axi_awready_out(s_axi_awready_out),
		.s_axi_wvalid_in(s_axi_wvalid_in),
		.s_axi_wdata_in(s_axi_wdata_in),
		.s_axi_wstrb_in(s_axi_wstrb_in),
		.s_axi_wready_out(s_axi_wready_out),
		.s_axi_bvalid_out(s_axi_bvalid_out),
		.s_axi_bresp_out(s_axi_bresp_out),
		.s_axi_bready_in(s_axi_bready_in),
		.s_axi_arvalid_in(s_axi_arvalid_in),
		.s_axi_araddr_in(s_axi_araddr_in),
		.s_axi_arready_out(s_axi_arready_out),
		.s_axi_rvalid_out(s_axi_rvalid_out),
		.s_axi_rdata_out(s_axi_rdata_out),
		.s_axi_rresp_out(s_axi_rresp_out),
		.s_axi_rready_in(s_axi_rready_in),
		.device_reset_out(device_reset_out),
		.wake_out(wake_out),
		.low_power_rc_clock_on_out(low_power_rc_clock_on_out),
		.sleep_out(sleep_out),
		.idle_out(idle_out)
	);

	// Reset pulses last one cycle and may end before a task returns
	always @(negedge clk_in)
	begin
		if (device_reset_out === 1'b1)
			rst_count++;
	end

	initial
	begin
		clk_in = 0;
		forever #10 clk_in = ~clk_in;
	end

	always @(posedge clk_in)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			bad_count++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic ta, tw, v;
		v = 0;
		@(posedge clk_in);
		s_axi_awvalid_in <= 1;
		s_axi_awaddr_in <= a;
		s_axi_wvalid_in <= 1;
		s_axi_wdata_in <= d;
		s_axi_bready_in <= 1;
		while (!v)
		begin
			@(negedge clk_in);
			ta = s_axi_awvalid_in && s_axi_awready_out;
			tw = s_axi_wvalid_in && s_axi_wready_out;
			v = s_axi_bvalid_out;
			rsp = s_axi_bresp_out;
			@(posedge clk_in);
			if (ta)
				s_axi_awvalid_in <= 0;
			if (tw)
				s_axi_wvalid_in <= 0;
		end
		s_axi_bready_in <= 0;
	endtask

	task automatic rd_reg(input logic [3:0] a);
		logic t, v;
		v = 0;
		@(posedge clk_in);
		s_axi_arvalid_in <= 1;
		s_axi_araddr_in <= a;
		s_axi_rready_in <= 1;
		while (!v)
		begin
			@(negedge clk_in);
			t = s_axi_arvalid_in && s_axi_arready_out;
			v = s_axi_rvalid_out;
			rd = s_axi_rdata_out;
			rsp = s_axi_rresp_out;
			@(posedge clk_in);
			if (t)
				s_axi_arvalid_in <= 0;
		end
		s_axi_rready_in <= 0;
	endtask

	// Cycles from start until the chosen pulse rises must fall inside lo..hi
	task automatic wait_rise(input string what, input bit sel_wake, input int start,
		input int lo, input int hi);
		int n;
		n = 0;
		do
		begin
			@(negedge clk_in);
			n = cyc - start;
		end
		while ((sel_wake ? wake_out : device_reset_out) !== 1'b1 && n <= hi);
		chk(what, 1, n >= lo && n <= hi);
	endtask

	initial
	begin
		{cyc, bad_count, n_tests, rst_count} = 0;
		{arst_n_in, clock_switch_done_in, s_axi_awvalid_in, s_axi_wvalid_in} = 0;
		{s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = 0;
		{s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 0;
		s_axi_wstrb_in = 4'hF;
		repeat (4) @(posedge clk_in);
		arst_n_in <= 1;
		rd_reg(CONFIG_OFFSET);
		chk("config", 32'h5F, rd);
		rd_reg(RESET_CONTROL_OFFSET);
		chk("reset_control", 32'h0, rd);
		rd_reg(STATUS_OFFSET);
		chk("status", 32'h0, rd & 32'h7FFF0001);
		rd_reg(4'h2);
		chk("unmapped resp", RESP_SLVERR, rsp);
		wr(4'h2, 32'h60);
		chk("unmapped write", RESP_SLVERR, rsp);
		s_axi_wstrb_in <= 4'hE;
		wr(CONFIG_OFFSET, 32'h60);
		s_axi_wstrb_in <= 4'hF;
		chk("masked write resp", RESP_OKAY, rsp);
		rd_reg(CONFIG_OFFSET);
		chk("masked config", 32'h5F, rd);
		wr(CONFIG_OFFSET, 32'h60);
		chk("write resp", RESP_OKAY, rsp);
		rd_reg(STATUS_OFFSET);
		chk("always on", 1, rd[0]);
		wr(CONFIG_OFFSET, 32'h40);
		rd_reg(STATUS_OFFSET);
		chk("soft off", 0, rd[0]);
		wr(RESET_CONTROL_OFFSET, 32'h20);
		rd_reg(STATUS_OFFSET);
		chk("soft on", 1, rd[0]);
		chk("rc pin", 1, low_power_rc_clock_on_out);
		repeat (200) @(posedge clk_in);
		wr(COMMAND_OFFSET, 32'h1);
		@(negedge clk_in);
		t0 = cyc;
		repeat (WIN - 200) @(posedge clk_in);
		rd_reg(STATUS_OFFSET);
		chk("window shut", 0, rd[1]);
		repeat (400) @(posedge clk_in);
		rd_reg(STATUS_OFFSET);
		chk("window open", 1, rd[1]);
		wait_rise("run timeout", 0, t0, PERIOD - SLACK, PERIOD + SLACK);
		rd_reg(RESET_CONTROL_OFFSET);
		chk("flag after reset", 32'h10, rd);
		wr(RESET_CONTROL_OFFSET, 32'h0);
		rd_reg(RESET_CONTROL_OFFSET);
		chk("flag cleared", 32'h0, rd);
		wr(CONFIG_OFFSET, 32'h00);
		wr(RESET_CONTROL_OFFSET, 32'h20);
		rst_base = rst_count;
		wr(COMMAND_OFFSET, 32'h1);
		@(negedge clk_in);
		chk("early kick", rst_base + 1, rst_count);
		rd_reg(RESET_CONTROL_OFFSET);
		chk("early kick flag", 32'h10, rd);
		wr(CONFIG_OFFSET, 32'h40);
		wr(RESET_CONTROL_OFFSET, 32'h20);
		repeat (200) @(posedge clk_in);
		rst_base = rst_count;
		wr(COMMAND_OFFSET, 32'h2);
		repeat (2) @(negedge clk_in);
		chk("sleep pin", 1, sleep_out);
		repeat (200) @(posedge clk_in);
		clock_switch_done_in <= 1;
		@(posedge clk_in);
		clock_switch_done_in <= 0;
		@(negedge clk_in);
		t0 = cyc;
		wait_rise("sleep wake", 1, t0, PERIOD - SLACK, PERIOD + SLACK);
		chk("no reset in sleep", rst_base, rst_count);
		repeat (3) @(negedge clk_in);
		chk("resumed", 0, sleep_out);
		rd_reg(RESET_CONTROL_OFFSET);
		chk("sleep status", 32'h38, rd);
		wr(RESET_CONTROL_OFFSET, 32'h20);
		rd_reg(RESET_CONTROL_OFFSET);
		chk("status cleared", 32'h20, rd);
		wr(COMMAND_OFFSET, 32'h4);
		repeat (2) @(negedge clk_in);
		chk("idle pin", 1, idle_out);
		wr(COMMAND_OFFSET, 32'h8);
		repeat (2) @(negedge clk_in);
		chk("idle left", 0, idle_out);
		rd_reg(RESET_CONTROL_OFFSET);
		chk("idle status", 32'h24, rd);
		@(posedge clk_in);
		arst_n_in <= 0;
		repeat (2) @(posedge clk_in);
		arst_n_in <= 1;
		rd_reg(RESET_CONTROL_OFFSET);
		chk("reset drops soft enable", 32'h0, rd);
		chk("rc pin off", 0, low_power_rc_clock_on_out);
		finish_test();
	end
endmodule
